// file: irq_ctrl_defs.vh
// Constants for the interrupt controller
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
`define ADDR_CONTROL   5'h00
`define ADDR_PFLAG     5'h04
`define ADDR_PENABLE   5'h08
`define ADDR_PINMASK   5'h0c
`define ADDR_OPTION    5'h10
`define ADDR_CORE      5'h14
`define CTL_GIE        7
`define CTL_PERIPH_GROUP_ENABLE       6
`define CTL_TIMER0_WRAP_ENABLE       5
`define CTL_EXT_PIN_ENABLE       4
`define CTL_PORT_CHANGE_ENABLE       3
`define CTL_TIMER0_WRAP_FLAG       2
`define CTL_EXT_PIN_FLAG       1
`define CTL_PORT_CHANGE_FLAG       0
`define PF_EE          7
`define PF_AD          6
`define PF_CM          3
`define PF_T1          0
`define PF_MASK        8'hc9
`define OPT_EDGE       0
`define VECTOR         13'h0004
`define LAT_CYCLES     2'h3
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define T0_ALL_ONES    8'hff
`endif

// file: irq_ctrl.v
// Interrupt controller with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
// Overview of operation
// - Seven sources: pin edge, timer0, pin change, comparator, conversion, timer1, write.
// - Global enable set services enabled requests; clear services none.
// - Each source has its own enable blocking its request.
// - Every reset clears the global enable.
// - Return-from-handler returns and sets the global enable.
// - Pin, pin-change, timer0 flags and enables live in control register.
// - Peripheral flags in peripheral flag register, enables in enable register.
// - Service clears global enable, pushes return address, loads vector 0004h.
// - Pin and port-change events reach the vector in three or four cycles.
// - Latency is independent of one- or two-cycle instructions.
// - Flags set on events regardless of any enable.
// - Clearing global enable ignores next-cycle requests, which stay pending.
// - Wake with global enable vectors to 0004h, else continues.
// - Wake source recorded in peripheral bits 7, 6, 3, 0; others unchanged.
// - Pin flag on rising edge if edge select set, else falling.
// - Timer0 change from all ones to any other value sets its flag.
// - Masked port pin change sets port-change flag.
// - Conversion done sets its flag.
module irq_ctrl (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        ext_request_pin,
   input  wire [7:0]  timer0_count,
   input  wire [5:0]  port_pins,
   input  wire        comparator_change,
   input  wire        conv_done,
   input  wire        timer1_wrap,
   input  wire        nv_write_done,
   input  wire [12:0] core_pc,
   input  wire        instr_boundary,
   input  wire        return_from_handler,
   input  wire        core_sleeping,
   output reg         irq_request,
   output reg         vector_load,
   output reg  [12:0] vector_addr,
   output reg         stack_push,
   output reg  [12:0] return_addr,
   output reg         wake
);

   localparam [2:0] ST_RUN  = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_TAKE = 3'b100;

   reg  [7:0]  irq_control_reg;
   reg  [7:0]  periph_flag_reg1;
   reg  [7:0]  periph_enable_reg1;
   reg  [5:0]  pin_change_mask;
   reg         ext_edge_select;
   reg         ext_pin_prev;
   reg  [7:0]  t0_prev;
   reg  [5:0]  port_prev;
   reg  [2:0]  state;
   reg  [1:0]  lat_cnt;
   reg         gie_block;
   reg         aw_held;
   reg         w_held;
   reg  [4:0]  aw_addr;
   reg  [31:0] w_data;
   reg         w_lane0;
   reg  [7:0]  next_control;
   reg  [7:0]  next_pflag;

   wire global_irq_enable   = irq_control_reg[`CTL_GIE];
   wire periph_group_enable = irq_control_reg[`CTL_PERIPH_GROUP_ENABLE];

   // Hardware event detectors
   // Pin, timer and port are edge-sensed here; the rest arrive as pulses
   wire ext_rise = ext_request_pin & ~ext_pin_prev;
   wire ext_fall = ~ext_request_pin & ext_pin_prev;
   wire ext_evt  = ext_edge_select ? ext_rise : ext_fall;
   wire t0_evt   = (t0_prev == `T0_ALL_ONES) && (timer0_count != `T0_ALL_ONES);
   wire port_evt = |((port_pins ^ port_prev) & pin_change_mask);

   // Enabled pending sources, global enable not yet applied
   wire core_pend = (irq_control_reg[`CTL_TIMER0_WRAP_ENABLE] & irq_control_reg[`CTL_TIMER0_WRAP_FLAG]) |
                    (irq_control_reg[`CTL_EXT_PIN_ENABLE] & irq_control_reg[`CTL_EXT_PIN_FLAG]) |
                    (irq_control_reg[`CTL_PORT_CHANGE_ENABLE] & irq_control_reg[`CTL_PORT_CHANGE_FLAG]);
   wire peri_pend = periph_group_enable &
                    |(periph_flag_reg1 & periph_enable_reg1 & `PF_MASK);
   wire pending   = core_pend | peri_pend;

   // Whole-address match: a misaligned offset must not alias a register
   function addr_hit;
      input [4:0] addr;
      input [4:0] reg_addr;
      begin
         addr_hit = (addr == reg_addr);
      end
   endfunction

   // Bus handshake
   wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire wr_ctl = wr_fire & w_lane0 & addr_hit(aw_addr, `ADDR_CONTROL);
   wire wr_pf  = wr_fire & w_lane0 & addr_hit(aw_addr, `ADDR_PFLAG);

   function wr_flag;
      input cur;
      input wbit;
      input evt;
      begin
         // Hardware set beats software clear
         wr_flag = evt | (cur & wbit);
      end
   endfunction

   wire take = (state == ST_TAKE);

   // Control and flag next values
   always @* begin
      next_control = irq_control_reg;
      next_pflag   = periph_flag_reg1;
      if (wr_ctl) begin
         next_control[7:3] = w_data[7:3];
      end
      next_control[`CTL_TIMER0_WRAP_FLAG] = wr_flag(irq_control_reg[`CTL_TIMER0_WRAP_FLAG],
                                        ~wr_ctl | w_data[`CTL_TIMER0_WRAP_FLAG], t0_evt);
      next_control[`CTL_EXT_PIN_FLAG] = wr_flag(irq_control_reg[`CTL_EXT_PIN_FLAG],
                                        ~wr_ctl | w_data[`CTL_EXT_PIN_FLAG], ext_evt);
      next_control[`CTL_PORT_CHANGE_FLAG] = wr_flag(irq_control_reg[`CTL_PORT_CHANGE_FLAG],
                                        ~wr_ctl | w_data[`CTL_PORT_CHANGE_FLAG], port_evt);
      next_pflag[`PF_EE] = wr_flag(periph_flag_reg1[`PF_EE],
                                   ~wr_pf | w_data[`PF_EE], nv_write_done);
      next_pflag[`PF_AD] = wr_flag(periph_flag_reg1[`PF_AD],
                                   ~wr_pf | w_data[`PF_AD], conv_done);
      next_pflag[`PF_CM] = wr_flag(periph_flag_reg1[`PF_CM],
                                   ~wr_pf | w_data[`PF_CM], comparator_change);
      next_pflag[`PF_T1] = wr_flag(periph_flag_reg1[`PF_T1],
                                   ~wr_pf | w_data[`PF_T1], timer1_wrap);
      if (return_from_handler) begin
         next_control[`CTL_GIE] = 1'b1;
      end
      if (take) begin
         next_control[`CTL_GIE] = 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_control_reg    <= 8'h00;
         periph_flag_reg1   <= 8'h00;
         periph_enable_reg1 <= 8'h00;
         pin_change_mask    <= 6'h00;
         ext_edge_select    <= 1'b1;
         // Track pins through reset so release shows no false edge
         ext_pin_prev       <= ext_request_pin;
         t0_prev            <= timer0_count;
         port_prev          <= port_pins;
      end else begin
         irq_control_reg  <= next_control;
         periph_flag_reg1 <= next_pflag;
         ext_pin_prev     <= ext_request_pin;
         t0_prev          <= timer0_count;
         port_prev        <= port_pins;
         if (wr_fire & w_lane0) begin
            case (aw_addr)
               `ADDR_PENABLE: periph_enable_reg1 <= w_data[7:0] & `PF_MASK;
               `ADDR_PINMASK: pin_change_mask    <= w_data[5:0];
               `ADDR_OPTION:  ext_edge_select    <= w_data[`OPT_EDGE];
               default: ;
            endcase
         end
      end
   end

   // Service sequencer: event latched, then fixed wait to a boundary
   always @(posedge aclk) begin
      if (!aresetn) begin
         state       <= ST_RUN;
         lat_cnt     <= 2'h0;
         gie_block   <= 1'b0;
         irq_request <= 1'b0;
         vector_load <= 1'b0;
         vector_addr <= 13'h0000;
         stack_push  <= 1'b0;
         return_addr <= 13'h0000;
         wake        <= 1'b0;
      end else begin
         vector_load <= 1'b0;
         stack_push  <= 1'b0;
         wake        <= 1'b0;
         // A global-enable clear masks requests in the very next cycle
         gie_block   <= wr_ctl & ~w_data[`CTL_GIE];
         irq_request <= global_irq_enable & pending;
         // Wake ignores the global enable; vectoring still needs it
         if (core_sleeping && pending) begin
            wake <= 1'b1;
         end
         case (state)
            ST_RUN: begin
               lat_cnt <= 2'h1;
               if (global_irq_enable & pending & ~gie_block) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Count is fixed so instruction length does not matter
               lat_cnt <= lat_cnt + 2'h1;
               if (!global_irq_enable) begin
                  state <= ST_RUN;
               end else if (lat_cnt == `LAT_CYCLES - 2'h1 && instr_boundary) begin
                  state <= ST_TAKE;
               end else if (lat_cnt == `LAT_CYCLES) begin
                  // Forced one cycle later: a long instruction must not stall entry
                  state <= ST_TAKE;
               end
            end
            ST_TAKE: begin
               vector_load <= 1'b1;
               vector_addr <= `VECTOR;
               stack_push  <= 1'b1;
               return_addr <= core_pc;
               state       <= ST_RUN;
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   // AXI4-Lite slave
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 5'h00;
         w_data       <= 32'h00000000;
         w_lane0      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
         // Response waits for both halves, so either arrival order works
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= `ADDR_OPTION) ?
                            `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            // Unmapped reads answer with an error and zero data
            case (s_axi_araddr)
               `ADDR_CONTROL: s_axi_rdata <= {24'h000000, irq_control_reg};
               `ADDR_PFLAG:   s_axi_rdata <= {24'h000000, periph_flag_reg1};
               `ADDR_PENABLE: s_axi_rdata <= {24'h000000, periph_enable_reg1};
               `ADDR_PINMASK: s_axi_rdata <= {26'h0000000, pin_change_mask};
               `ADDR_OPTION:  s_axi_rdata <= {31'h00000000, ext_edge_select};
               `ADDR_CORE:    s_axi_rdata <= {29'h00000000, state};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // irq_ctrl
`default_nettype wire

// file: irq_ctrl_monitor.sv
// Checker for the interrupt controller core-facing outputs
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
module irq_ctrl_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        irq_request,
   input wire logic        vector_load,
   input wire logic        stack_push,
   input wire logic [12:0] vector_addr,
   input wire logic        wake,
   input wire logic        core_sleeping
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence take_s;
      vector_load ##1 !vector_load;
   endsequence
   a_push_with_load: assert property (vector_load == stack_push)
      else $error("stack push and vector load differ");
   a_vector_value: assert property (vector_load |-> vector_addr == `VECTOR)
      else $error("vector address wrong at entry");
   a_load_pulse: assert property (vector_load |-> take_s)
      else $error("vector load longer than one cycle");
   a_take_quiet: assert property (take_s |=> !irq_request)
      else $error("request still up after entry");
   a_load_needs_req: assert property (vector_load |-> $past(irq_request))
      else $error("entry without request");
   a_take_latency: assert property ($rose(irq_request) && !core_sleeping |-> ##[2:5] vector_load)
      else $error("entry latency out of range");
   a_wake_sleep: assert property (wake |-> $past(core_sleeping))
      else $error("wake while core awake");
   a_reset_quiet: assert property ($rose(aresetn) |-> !irq_request && !vector_load && !wake)
      else $error("outputs active after reset");
endmodule // irq_ctrl_monitor
bind irq_ctrl irq_ctrl_monitor mon (.aclk(aclk), .aresetn(aresetn), .irq_request(irq_request),
   .vector_load(vector_load), .stack_push(stack_push), .vector_addr(vector_addr),
   .wake(wake), .core_sleeping(core_sleeping));
`default_nettype wire

// file: core_model.sv
// Core sequencer model driving pc and instruction boundaries
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        slow,
   input  wire logic        vector_load,
   input  wire logic [12:0] vector_addr,
   output logic      [12:0] core_pc,
   output logic             instr_boundary
);
   logic phase;
   // Two-cycle instructions leave a boundary every other cycle
   assign instr_boundary = !slow || phase;
   always @(posedge aclk) begin
      if (!aresetn) begin
         core_pc <= 13'h0000;
         phase <= 1'b0;
      end else begin
         phase <= !phase;
         if (vector_load) core_pc <= vector_addr;
         else if (instr_boundary) core_pc <= core_pc + 13'h0001;
      end
   end
endmodule // core_model
`default_nettype wire

// file: irq_ctrl_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
module irq_ctrl_tb;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic        pin = 0, cmp = 0, cd = 0, t1 = 0, nv = 0, rfh = 0, sleeping = 0, slow = 0;
   logic [4:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [7:0]  t0 = 0, v;
   logic [5:0]  pp = 0;
   logic [1:0]  r;
   logic [12:0] pc_seen;
   wire         awready, wready, bvalid, arready, rvalid, irq_request, vector_load;
   wire         stack_push, wake, boundary;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [12:0] pc, vector_addr, return_addr;
   int          fail_count = 0, total_checks = 0;
   logic [4:0]  ra [7] = '{5'h00, 5'h00, 5'h00, 5'h04, 5'h04, 5'h04, 5'h04};
   logic [7:0]  rv [7] = '{8'h02, 8'h04, 8'h01, 8'h08, 8'h40, 8'h01, 8'h80};
   always #4 aclk = ~aclk;
   irq_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_request_pin(pin),
      .timer0_count(t0), .port_pins(pp), .comparator_change(cmp), .conv_done(cd),
      .timer1_wrap(t1), .nv_write_done(nv), .core_pc(pc), .instr_boundary(boundary),
      .return_from_handler(rfh), .core_sleeping(sleeping), .irq_request(irq_request),
      .vector_load(vector_load), .vector_addr(vector_addr), .stack_push(stack_push),
      .return_addr(return_addr), .wake(wake));
   core_model cm (.aclk(aclk), .aresetn(aresetn), .slow(slow), .vector_load(vector_load),
      .vector_addr(vector_addr), .core_pc(pc), .instr_boundary(boundary));
   task automatic wrap_up;
      if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awv <= 1;
      wv <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awv && awready) awv <= 0;
         if (wv && wready) wv <= 0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a;
      arv <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arv && arready) arv <= 0;
      end while (rvalid !== 1'b1);
      v = rdata[7:0];
      r = rresp;
      rready <= 0;
   endtask
   task automatic fire(input int k);
      @(posedge aclk);
      case (k)
         0: pin <= 1;
         1: t0 <= 8'hff;
         2: pp <= ~pp;
         3: cmp <= 1;
         4: cd <= 1;
         5: t1 <= 1;
         default: nv <= 1;
      endcase
      @(posedge aclk);
      {pin, cmp, cd, t1, nv} <= 5'h00;
      t0 <= 8'h00;
   endtask
   task automatic wvec;
      repeat (12) begin
         @(posedge aclk);
         if (vector_load === 1'b1) break;
         pc_seen = pc;
      end
   endtask
   initial begin
      #100000;
      fail_count++;
      wrap_up;
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      wr(5'h0c, 32'h3f);
      chk("wr okay", `RESP_OKAY, r);
      for (int i = 0; i < 7; i++) begin
         fire(i);
         rd(ra[i]);
         chk("flag", rv[i], v);
         wr(ra[i], 0);
         rd(ra[i]);
         chk("cleared", 0, v);
      end
      // Both instruction lengths must give the same entry behaviour
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         wr(5'h08, 32'h40);
         wr(5'h00, 32'hc0);
         fire(4);
         wvec;
         chk("vload", 1, vector_load);
         chk("push", 1, stack_push);
         chk("vaddr", `VECTOR, vector_addr);
         chk("retaddr", pc_seen, return_addr);
         rd(5'h00);
         chk("gie off", 8'h40, v);
         rd(5'h04);
         chk("pending", 8'h40, v);
         wr(5'h04, 0);
         @(posedge aclk);
         rfh <= 1;
         @(posedge aclk);
         rfh <= 0;
         rd(5'h00);
         chk("gie on", 8'hc0, v);
      end
      wr(5'h00, 32'h40);
      fire(4);
      repeat (8) @(posedge aclk);
      chk("no req", 0, irq_request);
      wr(5'h00, 32'hc0);
      wvec;
      chk("late take", 1, vector_load);
      wr(5'h04, 0);
      wr(5'h08, 0);
      wr(5'h00, 32'hc0);
      fire(4);
      repeat (8) @(posedge aclk);
      chk("masked", 0, irq_request);
      wr(5'h04, 0);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(5'h00);
      chk("reset gie", 0, v);
      sleeping <= 1;
      wr(5'h08, 32'h01);
      wr(5'h00, 32'h40);
      fire(5);
      repeat (3) @(posedge aclk);
      chk("wake", 1, wake);
      chk("no vector", 0, vector_load);
      rd(5'h04);
      chk("wake flag", 8'h01, v);
      wr(5'h00, 32'hc0);
      wvec;
      chk("wake vector", 1, vector_load);
      wr(5'h01, 32'h00);
      chk("misaligned", `RESP_SLVERR, r);
      rd(5'h00);
      chk("no effect", 8'h40, v);
      rd(5'h18);
      chk("slverr", `RESP_SLVERR, r);
      wrap_up;
   end
endmodule // irq_ctrl_tb
`default_nettype wire
